//--- hw/kbd_pkg.sv
// shared constants and types for the keyboard repeat and character counter block
package kbd_pkg;

    // clock and element timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_US = 22000;
    localparam int BIT_CYCLES = BIT_TIME_US * 1000 / CLK_PERIOD_NS;

    // character frame and line geometry
    localparam int CODE_BITS = 5;
    localparam int CNT_W = 7;
    localparam int LINE_LEN = 72;
    localparam int WARN_SPACES = 6;
    localparam int WARN_POS = LINE_LEN - WARN_SPACES;

    // apb register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
    localparam logic [7:0] ADDR_INT_MASK = 8'h0c;

    // control register fields and reset value
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_BELL_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;

    // status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RPT_BIT = 1;
    localparam int STAT_LAMP_BIT = 2;
    localparam int STAT_CNT_LSB = 8;

    // interrupt status and mask fields
    localparam int IRQ_SENT_BIT = 0;
    localparam int IRQ_WARN_BIT = 1;
    localparam int IRQ_CLR_BIT = 2;
    localparam int IRQ_W = 3;
    localparam logic [2:0] MASK_RESET = 3'h0;

    // key classes presented by the keyboard pins
    typedef enum logic [2:0] {
        key_char,
        key_figures_shift,
        key_letters_shift,
        key_line_feed,
        key_return_to_margin
    } key_class_t;

    // transmitter cycle phases
    typedef enum logic [1:0] {
        st_idle,
        st_start,
        st_code,
        st_stop
    } tx_state_t;

endpackage

//--- hw/pin_sync.sv
// two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/10ps

module pin_sync #(
    parameter int W = 1
) (
    // clock, reset and enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // raw pins and synchronised copy
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q <= '0;
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule // pin_sync

//--- hw/kbd_xmit.sv
// keyboard transmitter: start-stop frames, character repeat, line counter and warning
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/10ps

// How it works
// [R1] while the character key and the repeat key stay down the same code is sent again and again.
// [R2] if repeat is up when the stop element begins, the character ends normally and the line rests.
// [R3] if repeat is still down at the stop element, the stop is sent and a new frame starts at once.
// [R4] the counter steps on every key or space bar, but not on the two shifts, line feed or return.
// [R5] the counter holds the number of characters sent since the last return to margin.
// [R6] the warning lamp lights once the counter is six spaces before the end of a standard line.
// [R7] with the bell fitted, a warning pulse is given when the counter reaches that same point.
// [R8] each counted cycle adds exactly one, at the end of the start element.
// [R9] between steps the counter keeps its value until stepped again or cleared.
// [R10] the two shifts and line feed still send a full frame but leave the counter alone.
// [R11] a return to margin clears the counter to zero.
// [R12] the shifts and line feed are not counted because they do not move the print position.
// [R13] a frame is a no-current start element, five code elements, then a current stop element.
// [R14] the operator releases the key before the next single character can be sent.
// [R15] the warning point is the 66th character position of a standard line.
module kbd_xmit #(
    parameter int unsigned BIT_CYCLES = kbd_pkg::BIT_CYCLES
) (
    // clock, reset and clock enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // keyboard pins
    input wire logic key_down,
    input wire logic [4:0] key_code,
    input wire logic [2:0] key_class,
    input wire logic repeat_down,
    // signal line and operator warnings
    output logic line_out,
    output logic margin_warning_lamp,
    output logic bell_pulse,
    output logic irq
);

    localparam int BW = $clog2(BIT_CYCLES + 1);
    localparam logic [BW-1:0] BIT_LAST = BW'(BIT_CYCLES - 1);
    localparam logic [2:0] CODE_LAST = 3'(kbd_pkg::CODE_BITS - 1);
    localparam logic [6:0] CNT_MAX = 7'h7f;
    localparam logic [6:0] WARN_AT = 7'(kbd_pkg::WARN_POS);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [9:0] pins_s;
    logic key_s;
    logic rpt_s;
    logic [4:0] code_s;
    kbd_pkg::key_class_t class_s;

    // code and class are mechanically settled before the key contact closes,
    // so the bus can share one synchroniser without a skew hazard
    pin_sync #(
        .W(10)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d({key_down, repeat_down, key_code, key_class}),
        .q(pins_s)
    );

    assign key_s = pins_s[9];
    assign rpt_s = pins_s[8];
    assign code_s = pins_s[7:3];
    assign class_s = kbd_pkg::key_class_t'(pins_s[2:0]);

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic [1:0] ctrl_q;
    logic [2:0] mask_q;
    logic [2:0] ist_q;
    logic [2:0] ist_d;
    logic enable;
    logic bell_fitted;

    assign enable = ctrl_q[kbd_pkg::CTRL_EN_BIT];
    assign bell_fitted = ctrl_q[kbd_pkg::CTRL_BELL_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // transmitter cycle

    kbd_pkg::tx_state_t state_q;
    logic [BW-1:0] bit_cnt_q;
    logic [2:0] idx_q;
    logic [4:0] code_q;
    logic [4:0] shreg_q;
    kbd_pkg::key_class_t cls_q;
    logic line_q;
    logic rpt_q;
    logic wait_rel_q;
    logic bit_end;
    logic start_ok;
    logic cycle_begin;
    logic frame_done;
    logic count_step;

    assign bit_end = (bit_cnt_q == BIT_LAST);
    // [R14] fresh press only
    assign start_ok = enable && key_s && !wait_rel_q;
    assign cycle_begin = (state_q == kbd_pkg::st_idle) && start_ok;
    assign frame_done = (state_q == kbd_pkg::st_stop) && bit_end;
    // [R8] step after start element
    assign count_step = (state_q == kbd_pkg::st_start) && bit_end;

    // element timer, restarted at every element boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q <= '0;
        end else if (ce) begin
            if (state_q == kbd_pkg::st_idle || bit_end) begin
                bit_cnt_q <= '0;
            end else begin
                bit_cnt_q <= bit_cnt_q + 1'b1;
            end
        end
    end

    // frame sequencer; the line rests at current level when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= kbd_pkg::st_idle;
            idx_q <= 3'h0;
            code_q <= 5'h00;
            shreg_q <= 5'h00;
            cls_q <= kbd_pkg::key_char;
            line_q <= 1'b1;
            rpt_q <= 1'b0;
        end else if (ce) begin
            case (state_q)
                kbd_pkg::st_idle: begin
                    line_q <= 1'b1;
                    // [R13] no-current start
                    if (start_ok) begin
                        state_q <= kbd_pkg::st_start;
                        code_q <= code_s;
                        shreg_q <= code_s;
                        cls_q <= class_s;
                        line_q <= 1'b0;
                    end
                end
                kbd_pkg::st_start: begin
                    // [R13] five code elements
                    if (bit_end) begin
                        state_q <= kbd_pkg::st_code;
                        line_q <= shreg_q[0];
                        shreg_q <= {1'b0, shreg_q[4:1]};
                        idx_q <= 3'h0;
                    end
                end
                kbd_pkg::st_code: begin
                    if (bit_end) begin
                        if (idx_q == CODE_LAST) begin
                            // [R13] current stop element
                            state_q <= kbd_pkg::st_stop;
                            line_q <= 1'b1;
                            // [R2] repeat sampled at stop
                            rpt_q <= rpt_s && key_s;
                        end else begin
                            line_q <= shreg_q[0];
                            shreg_q <= {1'b0, shreg_q[4:1]};
                            idx_q <= idx_q + 1'b1;
                        end
                    end
                end
                kbd_pkg::st_stop: begin
                    if (bit_end) begin
                        // [R3] restart without rest
                        if (rpt_q && enable) begin
                            state_q <= kbd_pkg::st_start;
                            shreg_q <= code_q;
                            line_q <= 1'b0;
                        end else begin
                            // [R2] halt as single stroke
                            state_q <= kbd_pkg::st_idle;
                            line_q <= 1'b1;
                        end
                        rpt_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= kbd_pkg::st_idle;
                    line_q <= 1'b1;
                end
            endcase
        end
    end

    // [R1] repeat keeps sending
    // a released key re-arms single sends; repeat frames bypass this lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_rel_q <= 1'b0;
        end else if (ce) begin
            if (!key_s) begin
                wait_rel_q <= 1'b0;
            end else if (cycle_begin) begin
                wait_rel_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // line character counter

    logic [6:0] cnt_q;
    logic counted;
    logic reach_warn;

    // [R12] shifts and line feed skipped
    assign counted = (cls_q == kbd_pkg::key_char);
    assign reach_warn = count_step && counted && (cnt_q == WARN_AT - 7'h01);

    // counter saturates rather than wrap, so an overlong line keeps the lamp lit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 7'h00;
        end else if (ce) begin
            // [R11] return clears to zero
            if (cycle_begin && class_s == kbd_pkg::key_return_to_margin) begin
                cnt_q <= 7'h00;
            // [R4] count characters
            end else if (count_step && counted && cnt_q != CNT_MAX) begin
                cnt_q <= cnt_q + 7'h01;
            end
            // [R10] other functions hold
            // [R9] otherwise holds value
        end
    end

    // [R6] lamp at warning point
    // [R15] position 66
    // [R7] bell pulse when reached
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            margin_warning_lamp <= 1'b0;
            bell_pulse <= 1'b0;
        end else if (ce) begin
            margin_warning_lamp <= (cnt_q >= WARN_AT);
            bell_pulse <= reach_warn && bell_fitted;
        end
    end

    // [R5] counts since last return
    assign line_out = line_q;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave, one wait state so that read data comes from a flip-flop

    logic access;
    logic done;
    logic hit;
    logic [31:0] rdata;
    logic rd_ist;

    assign access = psel && penable;
    assign done = access && pready;

    // address decode and read mux
    always_comb begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        if (paddr == kbd_pkg::ADDR_CTRL) begin
            rdata[1:0] = ctrl_q;
        end else if (paddr == kbd_pkg::ADDR_STATUS) begin
            rdata[kbd_pkg::STAT_BUSY_BIT] = (state_q != kbd_pkg::st_idle);
            rdata[kbd_pkg::STAT_RPT_BIT] = rpt_q;
            rdata[kbd_pkg::STAT_LAMP_BIT] = margin_warning_lamp;
            rdata[kbd_pkg::STAT_CNT_LSB +: kbd_pkg::CNT_W] = cnt_q;
        end else if (paddr == kbd_pkg::ADDR_INT_STATUS) begin
            rdata[2:0] = ist_q;
        end else if (paddr == kbd_pkg::ADDR_INT_MASK) begin
            rdata[2:0] = mask_q;
        end else begin
            hit = 1'b0;
        end
    end

    // answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            if (access && !pready) begin
                pready <= 1'b1;
                pslverr <= !hit;
                prdata <= pwrite ? 32'h0000_0000 : rdata;
            end else begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end
        end
    end

    // writable registers take effect at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= kbd_pkg::CTRL_RESET;
            mask_q <= kbd_pkg::MASK_RESET;
        end else if (ce) begin
            if (done && pwrite && paddr == kbd_pkg::ADDR_CTRL) begin
                ctrl_q <= pwdata[1:0];
            end else if (done && pwrite && paddr == kbd_pkg::ADDR_INT_MASK) begin
                mask_q <= pwdata[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupts: sticky events, cleared by reading, a new event wins the clear

    assign rd_ist = done && !pwrite && paddr == kbd_pkg::ADDR_INT_STATUS;

    always_comb begin
        ist_d = rd_ist ? 3'h0 : ist_q;
        if (frame_done) begin
            ist_d[kbd_pkg::IRQ_SENT_BIT] = 1'b1;
        end
        if (reach_warn) begin
            ist_d[kbd_pkg::IRQ_WARN_BIT] = 1'b1;
        end
        if (cycle_begin && class_s == kbd_pkg::key_return_to_margin) begin
            ist_d[kbd_pkg::IRQ_CLR_BIT] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_q <= 3'h0;
        end else if (ce) begin
            ist_q <= ist_d;
        end
    end

    assign irq = |(ist_q & mask_q);

endmodule // kbd_xmit

//--- verification/kbd_xmit_properties.sv
// port-level properties of the keyboard transmitter
`timescale 1ns/10ps

module kbd_xmit_props #(
    parameter int unsigned BIT_CYCLES = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb answer
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // keys, line and warnings
    input wire logic key_down,
    input wire logic repeat_down,
    input wire logic line_out,
    input wire logic margin_warning_lamp,
    input wire logic bell_pulse
);
    int unsigned pos_q;
    logic [7:0] hi_q;
    logic [7:0] lo_q;
    logic rk;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    assign rk = repeat_down && key_down;

    // frame position from the line alone; 0 is idle or the first start cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= 0;
        end else if (pos_q != 0 || !line_out) begin
            pos_q <= (pos_q == 7 * BIT_CYCLES - 1) ? 0 : pos_q + 1;
        end
    end

    // run lengths of repeat held or not; saturating so long idles stay safe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= 8'h00;
            lo_q <= 8'h00;
        end else begin
            hi_q <= rk ? hi_q + 8'(hi_q != 8'hff) : 8'h00;
            lo_q <= rk ? 8'h00 : lo_q + 8'(lo_q != 8'hff);
        end
    end

    ////////////////////////////////////////
    start_low_a: assert property (pos_q > 0 && pos_q < BIT_CYCLES |-> !line_out)
        else $error("start element not low");
    stop_high_a: assert property (pos_q >= 6 * BIT_CYCLES |-> line_out)
        else $error("stop element not high");
    repeat_next_a: assert property (
        pos_q == 7 * BIT_CYCLES - 1 && hi_q > BIT_CYCLES + 4 |=> !line_out)
        else $error("repeat did not restart");
    halt_rest_a: assert property (
        pos_q == 7 * BIT_CYCLES - 1 && lo_q > BIT_CYCLES + 4 |=> line_out [*2])
        else $error("line did not rest");
    lamp_rise_a: assert property ($rose(margin_warning_lamp) |->
        pos_q >= BIT_CYCLES && pos_q <= BIT_CYCLES + 2)
        else $error("lamp lit at wrong time");
    lamp_clear_a: assert property ($fell(margin_warning_lamp) |-> !line_out && pos_q <= 2)
        else $error("lamp dropped outside a frame start");
    bell_single_a: assert property (bell_pulse |=> !bell_pulse)
        else $error("bell pulse too long");
    bell_lamp_a: assert property (bell_pulse |-> ##[0:2] margin_warning_lamp)
        else $error("bell without lamp");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer malformed");
    ready_wait_a: assert property (psel && $rose(penable) |=> pready)
        else $error("pready not after one wait");

    repeat_c: cover property (pos_q == 7 * BIT_CYCLES - 1 && hi_q > BIT_CYCLES + 4);
    bell_c: cover property (bell_pulse);
    slverr_c: cover property (pslverr);
endmodule // kbd_xmit_props

bind kbd_xmit kbd_xmit_props #(.BIT_CYCLES(BIT_CYCLES)) props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .key_down(key_down), .repeat_down(repeat_down),
    .line_out(line_out), .margin_warning_lamp(margin_warning_lamp), .bell_pulse(bell_pulse)
);

//--- verification/rx_printer.sv
// receiving teleprinter model: decodes start-stop frames off the line
`timescale 1ns/10ps

module rx_printer #(
    parameter int unsigned BIT_CYCLES = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // line in, decoded character out
    input wire logic line_in,
    output logic [4:0] rx_code,
    output logic rx_valid,
    output logic rx_err
);
    int unsigned cnt_q;
    logic busy_q;
    logic [4:0] sh_q;

    ////////////////////////////////////////
    // frame decode
    // samples mid-element so a cycle of edge skew is tolerated
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 0;
            busy_q <= 1'b0;
            sh_q <= 5'h00;
            rx_code <= 5'h00;
            rx_valid <= 1'b0;
            rx_err <= 1'b0;
        end else if (!busy_q) begin
            busy_q <= !line_in;
            cnt_q <= 1;
            rx_valid <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 1;
            busy_q <= cnt_q != 7 * BIT_CYCLES - 1;
            rx_valid <= cnt_q == 6 * BIT_CYCLES + BIT_CYCLES / 2;
            if (cnt_q % BIT_CYCLES == BIT_CYCLES / 2) begin
                sh_q <= {line_in, sh_q[4:1]};
            end
            if (cnt_q == 6 * BIT_CYCLES + BIT_CYCLES / 2) begin
                rx_code <= sh_q;
                rx_err <= !line_in;
            end
        end
    end
endmodule // rx_printer

//--- verification/tb.sv
// self-checking bench for the keyboard transmitter
`timescale 1ns/10ps

module tb;
    localparam int unsigned BC = 4;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic key_down = 1'b0, repeat_down = 1'b0;
    logic [4:0] key_code = 5'h00;
    logic [2:0] key_class = 3'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, line_out, lamp, bell_pulse, irq, rx_valid, rx_err, er;
    logic [4:0] rx_code;
    int mismatches = 0, n_compared = 0, seed = 84133, rx_n = 0, bells = 0, exp_cnt = 0;

    always #5 pclk = ~pclk;

    kbd_xmit #(.BIT_CYCLES(BC)) dut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .key_down(key_down), .key_code(key_code), .key_class(key_class),
        .repeat_down(repeat_down), .line_out(line_out), .margin_warning_lamp(lamp),
        .bell_pulse(bell_pulse), .irq(irq));

    rx_printer #(.BIT_CYCLES(BC)) rx (.pclk(pclk), .presetn(presetn), .line_in(line_out),
        .rx_code(rx_code), .rx_valid(rx_valid), .rx_err(rx_err));

    // count decoded frames and bell pulses
    always @(posedge pclk) begin
        rx_n <= rx_n + int'(rx_valid);
        bells <= bells + int'(bell_pulse);
    end

    ////////////////////////////////////////
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    // a wait that runs out is counted and ends the run
    task automatic limit(input int i, input int lim);
        if (i >= lim) begin
            mismatches++;
            summarize();
        end
    endtask

    // one apb transfer, request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        limit(i, 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_rx;
        int i;
        for (i = 0; i < 20 * BC; i++) begin
            @(posedge pclk);
            if (rx_valid === 1'b1) break;
        end
        limit(i, 20 * BC);
    endtask

    function automatic int next_cnt(input int c, input logic [2:0] k);
        if (k == 3'h4) return 0;
        return (k == 3'h0) ? c + 1 : c;
    endfunction

    // one stroke without repeat, key held long, then count and lamp read back
    task automatic send(input logic [4:0] c, input logic [2:0] k);
        int n0;
        n0 = rx_n;
        key_code <= c;
        key_class <= k;
        @(posedge pclk);
        key_down <= 1'b1;
        wait_rx();
        chk_word(32'(rx_code), 32'(c));
        chk_bit(rx_err, 1'b0);
        repeat (14 * BC) @(posedge pclk);
        chk_word(32'(rx_n - n0), 32'h1);
        // key released before the next stroke
        key_down <= 1'b0;
        exp_cnt = next_cnt(exp_cnt, k);
        apb(1'b0, 8'h04, 32'h0);
        chk_word(32'(rd[14:8]), 32'(exp_cnt));
        chk_bit(lamp, exp_cnt >= 66);
    endtask

    initial begin
        static logic [7:0] adr [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
        static logic [31:0] rst [5] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
        int base;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk_bit(line_out, 1'b1);
        // status and unmapped writes change nothing; unmapped read refused
        apb(1'b1, 8'h04, 32'hffffffff);
        apb(1'b1, 8'h10, 32'hffffffff);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, adr[i], 32'h0);
            chk_word(rd, rst[i]);
            chk_bit(er, i == 4);
        end
        for (int k = 0; k < 5; k++) begin
            send(5'h1f - 5'(k), 3'(k));
        end
        // masked event keeps irq low; reading clears the sticky bits
        apb(1'b0, 8'h08, 32'h0);
        send(5'h00, 3'h1);
        chk_bit(irq, 1'b0);
        apb(1'b0, 8'h08, 32'h0);
        chk_word(rd, 32'h1);
        apb(1'b1, 8'h0c, 32'h7);
        send(5'h08, 3'h4);
        chk_bit(irq, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        chk_word(rd, 32'h5);
        @(negedge pclk);
        chk_bit(irq, 1'b0);
        for (int i = 0; i < 24; i++) begin
            send(5'($random(seed)), 3'($unsigned($random(seed)) % 5));
        end
        // a disabled transmitter sends nothing while a key is held
        apb(1'b1, 8'h00, 32'h0);
        base = rx_n;
        key_down <= 1'b1;
        repeat (10 * BC) @(posedge pclk);
        key_down <= 1'b0;
        chk_word(32'(rx_n - base), 32'h0);
        // bell fitted; a repeat burst passes the warning point
        apb(1'b1, 8'h00, 32'h3);
        send(5'h08, 3'h4);
        base = rx_n;
        key_code <= 5'h04;
        key_class <= 3'h0;
        repeat_down <= 1'b1;
        key_down <= 1'b1;
        for (int i = 1; i <= 70; i++) begin
            wait_rx();
            chk_word(32'(rx_code), 32'h04);
            chk_bit(lamp, i >= 66);
            // busy stays up between repeated frames
            if (i == 2) begin
                apb(1'b0, 8'h04, 32'h0);
                chk_bit(rd[0], 1'b1);
            end
        end
        repeat_down <= 1'b0;
        key_down <= 1'b0;
        repeat (21 * BC) @(posedge pclk);
        apb(1'b0, 8'h04, 32'h0);
        chk_word(32'(rd[14:8]), 32'(rx_n - base));
        chk_word(32'(bells), 32'h1);
        // warning event latched beside frame sent and return cleared
        apb(1'b0, 8'h08, 32'h0);
        chk_word(rd, 32'h7);
        exp_cnt = rx_n - base;
        send(5'h08, 3'h4);
        summarize();
    end
endmodule // tb
